// file: verilog/jdsc_port.v
// debug scan chain front end: shift register, command decode, cpu and bus access
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_regs.vh"

// Overview of operation
// - capture while selected loads reply into chain
// - shift-dr shifts one bit per test clock
// - update-dr takes chain contents as command
// - pause-dr leaves chain untouched, no action
// - respond to tap states only when selected
// - cross test clock safely into system clock
// - decode stall, reset, register and bus commands
// - second processor port, off by default
// - test reset input is active low
// - stall output high stops the processor
module jdsc_port #(
    parameter                     CPU1_EN = 1'b0
) (
    // clock and reset
    input  wire                   clk,
    input  wire                   rst,
    // tap side
    input  wire                   tck,
    input  wire                   tdi,
    output wire                   tdo,
    input  wire                   trst_n,
    input  wire                   capture_dr,
    input  wire                   shift_dr,
    input  wire                   update_dr,
    input  wire                   debug_select,
    // processor 0
    output wire                   cpu0_stall,
    output wire                   cpu0_rst,
    output wire                   cpu0_stb,
    input  wire                   cpu0_ack,
    input  wire [31:0]            cpu0_rdat,
    // processor 1
    output wire                   cpu1_stall,
    output wire                   cpu1_rst,
    output wire                   cpu1_stb,
    input  wire                   cpu1_ack,
    input  wire [31:0]            cpu1_rdat,
    // shared processor register access
    output wire                   cpu_we,
    output wire [31:0]            cpu_adr,
    output wire [31:0]            cpu_wdat,
    // system bus master
    output wire                   wb_cyc_o,
    output wire                   wb_stb_o,
    output wire                   wb_we_o,
    output wire [3:0]             wb_sel_o,
    output wire [31:0]            wb_adr_o,
    output wire [31:0]            wb_dat_o,
    input  wire                   wb_ack_i,
    input  wire                   wb_err_i,
    input  wire [31:0]            wb_dat_i
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_CPU  = 2'h1;
    localparam [1:0] ST_BUS  = 2'h2;

    // ==========================================================
    // input synchronisers
    wire [`JDSC_SYNC_W-1:0] s;

    jdsc_sync #(
        .WIDTH    (`JDSC_SYNC_W),
        .RST_VAL  (`JDSC_SYNC_RST)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({trst_n, debug_select, update_dr, shift_dr, capture_dr, tdi, tck}),
        .sync_out (s)
    );

    reg                      tck_d_ff;
    wire                     tck_rise;
    wire                     tck_fall;
    wire                     chain_rst;
    wire                     sel;

    assign chain_rst = rst | ~s[`JDSC_S_TRST_N];
    assign tck_rise  = s[`JDSC_S_TCK] & ~tck_d_ff;
    assign tck_fall  = ~s[`JDSC_S_TCK] & tck_d_ff;
    assign sel       = s[`JDSC_S_SEL];

    // ==========================================================
    // shift chain
    reg  [`JDSC_SR_W-1:0]    sr_ff;
    reg                      tdo_ff;
    reg                      ovr_ff;
    reg  [`JDSC_DAT_W-1:0]   rdata_ff;
    reg                      berr_ff;
    reg  [1:0]               state_ff;
    reg                      cpu_sel_ff;
    reg                      cpu0_stall_ff;
    reg                      cpu1_stall_ff;
    wire                     do_cap;
    wire                     do_shf;
    wire                     do_upd;
    wire                     buf_in_ready;
    wire                     buf_out_valid;
    wire                     buf_out_ready;
    wire [`JDSC_SR_W-1:0]    buf_out_data;
    wire [`JDSC_OP_W-1:0]    status;
    wire                     sel_stall;

    assign do_cap = tck_rise & sel & s[`JDSC_S_CAP];
    assign do_shf = tck_rise & sel & s[`JDSC_S_SHF];
    assign do_upd = tck_rise & sel & s[`JDSC_S_UPD];

    assign sel_stall = cpu_sel_ff ? cpu1_stall_ff : cpu0_stall_ff;
    assign status[`JDSC_ST_STALL] = sel_stall;
    assign status[`JDSC_ST_BERR]  = berr_ff;
    assign status[`JDSC_ST_OVR]   = ovr_ff;
    assign status[`JDSC_ST_BUSY]  = (state_ff != ST_IDLE) | buf_out_valid;

    always @(posedge clk) begin
        if (chain_rst) begin
            tck_d_ff <= 1'b0;
            sr_ff    <= `JDSC_ZERO36;
            tdo_ff   <= 1'b0;
            ovr_ff   <= 1'b0;
        end else begin
            tck_d_ff <= s[`JDSC_S_TCK];
            if (do_cap) begin
                sr_ff <= {status, rdata_ff};
            end else if (do_shf) begin
                sr_ff <= {s[`JDSC_S_TDI], sr_ff[`JDSC_SR_MSB:`JDSC_SR_LSB1]};
            end
            // pause and other states leave the chain alone
            if (tck_fall & sel) begin
                tdo_ff <= sr_ff[0];
            end
            // a lost update wins over the clear on capture
            if (do_upd & ~buf_in_ready) begin
                ovr_ff <= 1'b1;
            end else if (do_cap) begin
                ovr_ff <= 1'b0;
            end
        end
    end

    assign tdo = tdo_ff;

    // ==========================================================
    // command buffer
    jdsc_buf #(
        .WIDTH     (`JDSC_SR_W)
    ) u_buf (
        .clk       (clk),
        .rst       (chain_rst),
        .in_valid  (do_upd),
        .in_ready  (buf_in_ready),
        .in_data   (sr_ff),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    assign buf_out_ready = (state_ff == ST_IDLE);

    // ==========================================================
    // command execution
    wire [`JDSC_OP_W-1:0]    op;
    wire [`JDSC_DAT_W-1:0]   arg;
    wire                     exec;
    wire                     cpu_ack_sel;
    wire [`JDSC_DAT_W-1:0]   cpu_rdat_sel;

    assign op           = buf_out_data[`JDSC_OP_HI:`JDSC_OP_LO];
    assign arg          = buf_out_data[`JDSC_DAT_HI:0];
    assign exec         = buf_out_valid & buf_out_ready;
    assign cpu_ack_sel  = cpu_sel_ff ? cpu1_ack : cpu0_ack;
    assign cpu_rdat_sel = cpu_sel_ff ? cpu1_rdat : cpu0_rdat;

    reg                      cpu0_rst_ff;
    reg                      cpu1_rst_ff;
    reg                      cpu0_stb_ff;
    reg                      cpu1_stb_ff;
    reg                      cpu_we_ff;
    reg  [`JDSC_DAT_W-1:0]   cpu_adr_ff;
    reg  [`JDSC_DAT_W-1:0]   cpu_wdat_ff;
    reg                      wb_cyc_ff;
    reg                      wb_we_ff;
    reg  [`JDSC_DAT_W-1:0]   wb_adr_ff;
    reg  [`JDSC_DAT_W-1:0]   wb_dat_ff;

    always @(posedge clk) begin
        if (rst) begin
            state_ff      <= ST_IDLE;
            cpu_sel_ff    <= 1'b0;
            cpu0_stall_ff <= 1'b0;
            cpu1_stall_ff <= 1'b0;
            cpu0_rst_ff   <= 1'b0;
            cpu1_rst_ff   <= 1'b0;
            cpu0_stb_ff   <= 1'b0;
            cpu1_stb_ff   <= 1'b0;
            cpu_we_ff     <= 1'b0;
            cpu_adr_ff    <= `JDSC_ZERO32;
            cpu_wdat_ff   <= `JDSC_ZERO32;
            wb_cyc_ff     <= 1'b0;
            wb_we_ff      <= 1'b0;
            wb_adr_ff     <= `JDSC_ZERO32;
            wb_dat_ff     <= `JDSC_ZERO32;
            rdata_ff      <= `JDSC_ZERO32;
            berr_ff       <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (exec) begin
                        case (op)
                            `JDSC_OP_STALL: begin
                                if (cpu_sel_ff) begin
                                    cpu1_stall_ff <= arg[0];
                                end else begin
                                    cpu0_stall_ff <= arg[0];
                                end
                            end
                            `JDSC_OP_RESET: begin
                                if (cpu_sel_ff) begin
                                    cpu1_rst_ff <= arg[0];
                                end else begin
                                    cpu0_rst_ff <= arg[0];
                                end
                            end
                            `JDSC_OP_CPU_ADR: begin
                                cpu_adr_ff <= arg;
                            end
                            `JDSC_OP_CPU_WR, `JDSC_OP_CPU_RD: begin
                                cpu_wdat_ff <= arg;
                                cpu_we_ff   <= (op == `JDSC_OP_CPU_WR);
                                cpu0_stb_ff <= ~cpu_sel_ff;
                                cpu1_stb_ff <= cpu_sel_ff;
                                state_ff    <= ST_CPU;
                            end
                            `JDSC_OP_BUS_ADR: begin
                                wb_adr_ff <= arg;
                            end
                            `JDSC_OP_BUS_WR, `JDSC_OP_BUS_RD: begin
                                wb_dat_ff <= arg;
                                wb_we_ff  <= (op == `JDSC_OP_BUS_WR);
                                wb_cyc_ff <= 1'b1;
                                berr_ff   <= 1'b0;
                                state_ff  <= ST_BUS;
                            end
                            `JDSC_OP_CPU_SEL: begin
                                cpu_sel_ff <= arg[0] & CPU1_EN;
                            end
                            default: begin
                                state_ff <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_CPU: begin
                    if (cpu_ack_sel) begin
                        cpu0_stb_ff <= 1'b0;
                        cpu1_stb_ff <= 1'b0;
                        if (~cpu_we_ff) begin
                            rdata_ff <= cpu_rdat_sel;
                        end
                        state_ff <= ST_IDLE;
                    end
                end
                ST_BUS: begin
                    if (wb_ack_i | wb_err_i) begin
                        wb_cyc_ff <= 1'b0;
                        berr_ff   <= wb_err_i;
                        if (~wb_we_ff & wb_ack_i) begin
                            rdata_ff <= wb_dat_i;
                        end
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign cpu0_stall = cpu0_stall_ff;
    assign cpu1_stall = cpu1_stall_ff;
    assign cpu0_rst   = cpu0_rst_ff;
    assign cpu1_rst   = cpu1_rst_ff;
    assign cpu0_stb   = cpu0_stb_ff;
    assign cpu1_stb   = cpu1_stb_ff;
    assign cpu_we     = cpu_we_ff;
    assign cpu_adr    = cpu_adr_ff;
    assign cpu_wdat   = cpu_wdat_ff;
    assign wb_cyc_o   = wb_cyc_ff;
    assign wb_stb_o   = wb_cyc_ff;
    assign wb_we_o    = wb_we_ff;
    assign wb_sel_o   = `JDSC_SEL_ALL;
    assign wb_adr_o   = wb_adr_ff;
    assign wb_dat_o   = wb_dat_ff;

endmodule

`default_nettype wire

// file: verilog/jdsc_regs.vh
// constants of the debug scan chain port
`ifndef JDSC_REGS_VH
`define JDSC_REGS_VH

// ==========================================================
// frame layout
`define JDSC_SR_W        36
`define JDSC_DAT_W       32
`define JDSC_OP_W        4
`define JDSC_OP_HI       35
`define JDSC_OP_LO       32
`define JDSC_DAT_HI      31
`define JDSC_SR_MSB      35
`define JDSC_SR_LSB1     1

// ==========================================================
// opcodes of a command frame
`define JDSC_OP_NOP      4'h0
`define JDSC_OP_STALL    4'h1
`define JDSC_OP_RESET    4'h2
`define JDSC_OP_CPU_ADR  4'h3
`define JDSC_OP_CPU_WR   4'h4
`define JDSC_OP_CPU_RD   4'h5
`define JDSC_OP_BUS_ADR  4'h6
`define JDSC_OP_BUS_WR   4'h7
`define JDSC_OP_BUS_RD   4'h8
`define JDSC_OP_CPU_SEL  4'h9

// ==========================================================
// synchroniser bit positions
`define JDSC_SYNC_W      7
`define JDSC_S_TCK       0
`define JDSC_S_TDI       1
`define JDSC_S_CAP       2
`define JDSC_S_SHF       3
`define JDSC_S_UPD       4
`define JDSC_S_SEL       5
`define JDSC_S_TRST_N    6
`define JDSC_SYNC_RST    7'h40

// ==========================================================
// status nibble bit positions
`define JDSC_ST_STALL    0
`define JDSC_ST_BERR     1
`define JDSC_ST_OVR      2
`define JDSC_ST_BUSY     3

// ==========================================================
// reset values and misc
`define JDSC_ZERO32      32'h00000000
`define JDSC_ZERO36      36'h000000000
`define JDSC_SEL_ALL     4'hF
`define JDSC_BUF_DEPTH   2

`endif

// file: verilog/jdsc_sync.v
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_regs.vh"

module jdsc_sync #(
    parameter                 WIDTH = `JDSC_SYNC_W,
    parameter [WIDTH-1:0]     RST_VAL = `JDSC_SYNC_RST
) (
    // clock and reset
    input  wire               clk,
    input  wire               rst,
    // asynchronous inputs
    input  wire [WIDTH-1:0]   async_in,
    // synchronised outputs
    output wire [WIDTH-1:0]   sync_out
);

    // ==========================================================
    // per-bit stages
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_ff;
            reg stab_ff;
            always @(posedge clk) begin
                if (rst) begin
                    meta_ff <= RST_VAL[i];
                    stab_ff <= RST_VAL[i];
                end else begin
                    meta_ff <= async_in[i];
                    stab_ff <= meta_ff;
                end
            end
            assign sync_out[i] = stab_ff;
        end
    endgenerate

endmodule

`default_nettype wire

// file: verilog/jdsc_buf.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_regs.vh"

module jdsc_buf #(
    parameter                 WIDTH = `JDSC_SR_W
) (
    // clock and reset
    input  wire               clk,
    input  wire               rst,
    // filling side
    input  wire               in_valid,
    output wire               in_ready,
    input  wire [WIDTH-1:0]   in_data,
    // draining side
    output wire               out_valid,
    input  wire               out_ready,
    output wire [WIDTH-1:0]   out_data
);

    reg [WIDTH-1:0] mem [0:1];
    reg             wr_ff;
    reg             rd_ff;
    reg [1:0]       cnt_ff;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = mem[rd_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // ==========================================================
    // storage and pointers
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) begin
                wr_ff <= ~wr_ff;
            end
            if (pop) begin
                rd_ff <= ~rd_ff;
            end
            if (push & ~pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop & ~push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// file: test/jdsc_port_asserts.sv
// checker of the debug scan chain port pins
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_regs.vh"

module jdsc_port_chk #(
    parameter CPU1_EN = 1'b0
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // tap side
    input wire logic        tck,
    input wire logic        trst_n,
    input wire logic        tdo,
    input wire logic        debug_select,
    // processors
    input wire logic        cpu0_stb,
    input wire logic        cpu0_ack,
    input wire logic        cpu0_stall,
    input wire logic        cpu1_stall,
    input wire logic        cpu1_rst,
    input wire logic        cpu1_stb,
    input wire logic        cpu_we,
    input wire logic [31:0] cpu_adr,
    // system bus
    input wire logic        wb_cyc_o,
    input wire logic        wb_stb_o,
    input wire logic        wb_we_o,
    input wire logic [3:0]  wb_sel_o,
    input wire logic [31:0] wb_adr_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_i,
    input wire logic        wb_err_i
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================
    // tap side
    a_tdo_on_fall: assert property ($changed(tdo) && $past(trst_n, 3) |->
        !$past(tck) && ($past(tck, 4) || $past(tck, 5)))
        else $error("tdo moved away from a test clock fall");
    a_unsel_quiet: assert property (!debug_select [*4] |=> $stable(tdo))
        else $error("tdo moved while not selected");

    // ==========================================
    // processor side
    a_cpu_hold: assert property (cpu0_stb && !cpu0_ack |=>
        cpu0_stb && $stable({cpu_we, cpu_adr}))
        else $error("processor request dropped or changed early");
    a_cpu_end: assert property (cpu0_stb && cpu0_ack |=> !cpu0_stb)
        else $error("processor strobe outlived its ack");
    a_cpu1_off: assert property (CPU1_EN == 1'b0 |->
        !cpu1_stb && !cpu1_stall && !cpu1_rst)
        else $error("second processor port active");

    // ==========================================
    // system bus
    a_cyc_pair: assert property (wb_cyc_o == wb_stb_o)
        else $error("bus cycle and strobe differ");
    a_bus_lanes: assert property (wb_sel_o == `JDSC_SEL_ALL)
        else $error("byte lanes not all enabled");
    a_bus_hold: assert property (wb_stb_o && !wb_ack_i && !wb_err_i
        |=> wb_stb_o && $stable({wb_we_o, wb_adr_o, wb_dat_o}))
        else $error("bus request dropped or changed early");
    a_bus_end: assert property (wb_stb_o && (wb_ack_i || wb_err_i) |=> !wb_stb_o)
        else $error("bus strobe outlived its answer");
    a_one_access: assert property (!(cpu0_stb && wb_stb_o))
        else $error("processor and bus access at once");

    c_stall: cover property ($rose(cpu0_stall));
    c_bus_err: cover property (wb_stb_o && wb_err_i);
    c_cpu_read: cover property (cpu0_stb && cpu0_ack && !cpu_we);
endmodule

bind jdsc_port jdsc_port_chk #(.CPU1_EN(CPU1_EN)) u_chk (
    .clk(clk), .rst(rst), .tck(tck), .trst_n(trst_n), .tdo(tdo), .debug_select(debug_select),
    .cpu0_stb(cpu0_stb), .cpu0_ack(cpu0_ack), .cpu0_stall(cpu0_stall),
    .cpu1_stall(cpu1_stall), .cpu1_rst(cpu1_rst), .cpu1_stb(cpu1_stb),
    .cpu_we(cpu_we), .cpu_adr(cpu_adr), .wb_cyc_o(wb_cyc_o), .wb_stb_o(wb_stb_o),
    .wb_we_o(wb_we_o), .wb_sel_o(wb_sel_o), .wb_adr_o(wb_adr_o), .wb_dat_o(wb_dat_o),
    .wb_ack_i(wb_ack_i), .wb_err_i(wb_err_i)
);
`default_nettype wire

// file: test/jdsc_tap_model.sv
// test access port model driving the chain
`timescale 1ns/1ps
`default_nettype none

module jdsc_tap_model (
    // system clock
    input wire logic clk,
    // tap lines
    input wire logic tdo,
    output logic     tck,
    output logic     tdi,
    output logic     trst_n,
    output logic     capture_dr,
    output logic     shift_dr,
    output logic     update_dr,
    output logic     debug_select
);
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        trst_n = 1'b1;
        capture_dr = 1'b0;
        shift_dr = 1'b0;
        update_dr = 1'b0;
        debug_select = 1'b0;
    end

    // ==========================================
    // half test clock, four system clocks
    task tick(input v);
        begin
            repeat (4) @(posedge clk);
            tck <= v;
        end
    endtask

    // ==========================================
    // capture, shift with a pause, update
    task frame(input [35:0] c, input s, output [35:0] q);
        integer n;
        begin
            debug_select <= s;
            capture_dr <= 1'b1;
            tick(1'b1);
            tick(1'b0);
            capture_dr <= 1'b0;
            shift_dr <= 1'b1;
            for (n = 0; n < 36; n = n + 1) begin
                if (n == 18) begin
                    shift_dr <= 1'b0;
                    tdi <= ~c[n];
                    tick(1'b1);
                    tick(1'b0);
                    shift_dr <= 1'b1;
                end
                tdi <= c[n];
                repeat (4) @(posedge clk);
                q[n] = tdo;
                tck <= 1'b1;
                tick(1'b0);
            end
            shift_dr <= 1'b0;
            update_dr <= 1'b1;
            tdi <= ~tdi;
            tick(1'b1);
            tick(1'b0);
            update_dr <= 1'b0;
        end
    endtask

    task chain_reset;
        begin
            @(posedge clk);
            trst_n <= 1'b0;
            repeat (4) @(posedge clk);
            trst_n <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// file: test/jtag_debug_scan_chain_port_tb.sv
// self-checking bench of the debug scan chain port
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_regs.vh"

`define CHK(a, e) begin cmp_count = cmp_count + 1; if ((a) !== (e)) begin \
    miscompares = miscompares + 1; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (a), (e)); end end

module jtag_debug_scan_chain_port_tb;
    logic clk = 1'b0, rst = 1'b1, cpu0_ack = 1'b0, wb_ack_i = 1'b0, wb_err_i = 1'b0;
    logic [31:0] cpu0_rdat = 32'h0, wb_dat_i = 32'h0;
    wire tck, tdi, tdo, trst_n, capture_dr, shift_dr, update_dr, debug_select;
    wire cpu0_stall, cpu0_rst, cpu0_stb, cpu1_stall, cpu1_rst, cpu1_stb, cpu_we;
    wire wb_cyc_o, wb_stb_o, wb_we_o;
    wire [3:0] wb_sel_o;
    wire [31:0] cpu_adr, cpu_wdat, wb_adr_o, wb_dat_o;
    reg m_stall = 1'b0, m_rst = 1'b0, m_berr = 1'b0, hold = 1'b0, err_mode = 1'b0, f;
    reg [31:0] m_rdat = 32'h0, m_cadr = 32'h0, m_badr = 32'h0, r;
    reg [64:0] exp_c[$], exp_b[$], e;
    reg [35:0] q, c;
    integer seed = 82468, miscompares = 0, cmp_count = 0, p, i, k;

    initial begin
        forever #25 clk = ~clk;
    end

    jdsc_tap_model tap (.clk(clk), .tdo(tdo), .tck(tck), .tdi(tdi), .trst_n(trst_n),
        .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr),
        .debug_select(debug_select));

    jdsc_port DUT (.clk(clk), .rst(rst), .tck(tck), .tdi(tdi), .tdo(tdo), .trst_n(trst_n),
        .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr),
        .debug_select(debug_select), .cpu0_stall(cpu0_stall), .cpu0_rst(cpu0_rst),
        .cpu0_stb(cpu0_stb), .cpu0_ack(cpu0_ack), .cpu0_rdat(cpu0_rdat),
        .cpu1_stall(cpu1_stall), .cpu1_rst(cpu1_rst), .cpu1_stb(cpu1_stb),
        .cpu1_ack(1'b0), .cpu1_rdat(32'h0), .cpu_we(cpu_we), .cpu_adr(cpu_adr),
        .cpu_wdat(cpu_wdat), .wb_cyc_o(wb_cyc_o), .wb_stb_o(wb_stb_o), .wb_we_o(wb_we_o),
        .wb_sel_o(wb_sel_o), .wb_adr_o(wb_adr_o), .wb_dat_o(wb_dat_o),
        .wb_ack_i(wb_ack_i), .wb_err_i(wb_err_i), .wb_dat_i(wb_dat_i));

    // ==========================================
    // processor and bus responders
    always @(posedge clk) begin
        cpu0_ack <= 1'b0;
        if (cpu0_stb && !cpu0_ack && ($random(seed) & 1)) begin
            e = exp_c.pop_front();
            `CHK({cpu_we, cpu_adr, cpu_we ? cpu_wdat : 32'h0}, e)
            r = $random(seed);
            cpu0_ack <= 1'b1;
            cpu0_rdat <= r;
            if (!cpu_we) m_rdat = r;
        end
    end

    always @(posedge clk) begin
        wb_ack_i <= 1'b0;
        wb_err_i <= 1'b0;
        if (wb_stb_o && !wb_ack_i && !wb_err_i && !hold && ($random(seed) & 1)) begin
            e = exp_b.pop_front();
            `CHK({wb_we_o, wb_adr_o, wb_we_o ? wb_dat_o : 32'h0}, e)
            r = $random(seed);
            f = err_mode & wb_we_o;
            wb_err_i <= f;
            wb_ack_i <= !f;
            wb_dat_i <= r;
            m_berr = f;
            if (!wb_we_o) m_rdat = r;
        end
    end

    // ==========================================
    // reference model of command effects
    task apply(input [35:0] a);
        begin
            case (a[35:32])
                `JDSC_OP_STALL: m_stall = a[0];
                `JDSC_OP_RESET: m_rst = a[0];
                `JDSC_OP_CPU_ADR: m_cadr = a[31:0];
                `JDSC_OP_CPU_WR: exp_c.push_back({1'b1, m_cadr, a[31:0]});
                `JDSC_OP_CPU_RD: exp_c.push_back({1'b0, m_cadr, 32'h0});
                `JDSC_OP_BUS_ADR: m_badr = a[31:0];
                `JDSC_OP_BUS_WR: exp_b.push_back({1'b1, m_badr, a[31:0]});
                `JDSC_OP_BUS_RD: exp_b.push_back({1'b0, m_badr, 32'h0});
                default: ;
            endcase
        end
    endtask

    task send(input [35:0] a);
        begin
            repeat (30) @(posedge clk);
            `CHK({cpu0_stall, cpu0_rst}, {m_stall, m_rst})
            tap.frame(a, 1'b1, q);
            `CHK(q, {2'b00, m_berr, m_stall, m_rdat})
            apply(a);
        end
    endtask

    task report_and_stop;
        begin
            $display("compares %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        miscompares = miscompares + 1;
        report_and_stop;
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (p = 0; p < 3; p = p + 1) begin
            err_mode = (p == 1);
            for (i = 0; i < 10; i = i + 1) begin
                r = $random(seed);
                if (i == 1 || i == 2 || i == 9) r = r & 32'h1;
                send({i[3:0], r});
            end
        end
        // unselected frame leaves everything alone
        tap.frame({`JDSC_OP_STALL, 31'h0, !m_stall}, 1'b0, q);
        send({`JDSC_OP_NOP, 32'h0});
        // stalled bus fills the buffer until it refuses
        hold = 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            c = {`JDSC_OP_BUS_WR, $random(seed)};
            tap.frame(c, 1'b1, q);
            if (k < 3) apply(c);
        end
        tap.frame({`JDSC_OP_NOP, 32'h0}, 1'b1, q);
        `CHK(q[35:34], 2'b11)
        hold = 1'b0;
        repeat (200) @(posedge clk);
        tap.chain_reset;
        send({`JDSC_OP_NOP, 32'h0});
        send({`JDSC_OP_STALL, 32'h0});
        send({`JDSC_OP_NOP, 32'h0});
        report_and_stop;
    end
endmodule
`default_nettype wire
